// [dv/test_phy_test_mode_entry.sv]
`timescale 1ns/1ps
`default_nettype none
module test_phy_test_mode_entry;
   import pte_pkg::*;

   localparam int unsigned RUN = 10;

   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  tx_symbol_in = 2'h0;
   logic [1:0]  tx_symbol;
   logic        tx_path_enable;
   logic        rx_path_enable;
   logic        force_master;
   logic        high_swing_strap_n = 1'b0;
   logic        high_swing_allowed;
   logic        high_swing_active;
   logic        led_state_a = 1'b1;
   logic        led_state_b = 1'b1;
   logic        ext_a = 1'b1;
   logic        ext_b = 1'b0;
   wire logic   pin_a;
   wire logic   pin_b;
   logic        a_o, a_oe, b_o, b_oe;
   logic        pull_up_a;
   logic        pull_down_b;
   int          fails = 0;
   int          tests_run = 0;
   logic [31:0] q;
   logic [3:0]  be = 4'hF;

   // Pin level: the design drives it, else the board's pull decides
   assign pin_a = a_oe ? a_o : ext_a;
   assign pin_b = b_oe ? b_o : ext_b;

   always #10 clk = ~clk;

   pte_top #(.PD_CYCLES(3), .SENSE_CYCLES(2), .RUN_LEN(RUN)) pte_top_i (
      .clk                       (clk),
      .nrst                      (nrst),
      .avs_address               (avs_address),
      .avs_read                  (avs_read),
      .avs_write                 (avs_write),
      .avs_writedata             (avs_writedata),
      .avs_byteenable            (avs_byteenable),
      .avs_readdata              (avs_readdata),
      .avs_waitrequest           (avs_waitrequest),
      .tx_symbol_in              (tx_symbol_in),
      .tx_symbol                 (tx_symbol),
      .tx_path_enable            (tx_path_enable),
      .rx_path_enable            (rx_path_enable),
      .force_master              (force_master),
      .high_swing_strap_n        (high_swing_strap_n),
      .high_swing_allowed        (high_swing_allowed),
      .high_swing_active         (high_swing_active),
      .led_state_a               (led_state_a),
      .led_state_b               (led_state_b),
      .indicator_pin_a_i         (pin_a),
      .indicator_pin_a_o         (a_o),
      .indicator_pin_a_oe        (a_oe),
      .indicator_pin_a_pull_up   (pull_up_a),
      .indicator_pin_b_i         (pin_b),
      .indicator_pin_b_o         (b_o),
      .indicator_pin_b_oe        (b_oe),
      .indicator_pin_b_pull_down (pull_down_b)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      chk(n, 2);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic do_reset;
      nrst <= 1'b0;
      cyc(20);
      nrst <= 1'b1;
      cyc(10);
   endtask

   initial begin
      #200_000;
      fails++;
      report_and_stop;
   end

   initial begin
      do_reset;
      rd(REG_CTRL);
      chk(q, 32'h0000_0002);
      rd(REG_STAT);
      chk(q, 32'h0000_0024);
      chk({pull_up_a, pull_down_b}, 2'b11);
      chk(high_swing_allowed, 1'b1);
      // polarity modes, code 3 acts as autosense
      for (int p = 0; p < 4; p++) begin
         wr(REG_LED, 32'(p * 5));
         cyc(3);
         chk(a_o, (p == 2) ? 1'b1 : 1'b0);
         chk(b_o, (p == 1) ? 1'b0 : 1'b1);
         chk({a_oe, b_oe}, 2'b11);
      end
      wr(REG_CTRL, 32'h12);
      cyc(2);
      chk({high_swing_allowed, high_swing_active}, 2'b10);
      wr(REG_CTRL, 32'h02);
      wr(REG_TEST, 32'h1);
      tx_symbol_in <= SYM_NEG;
      cyc(4);
      chk(tx_symbol, SYM_NEG);
      wr(REG_CTRL, 32'h03);
      cyc(8);
      rd(REG_STAT);
      chk(q[ST_PD_RDY], 1'b1);
      chk(tx_path_enable, 1'b0);
      wr(REG_CTRL, 32'h01);
      wr(REG_CTRL, 32'h05);
      // each pattern code after the entry sequence
      for (int c = 1; c < 4; c++) begin
         wr(REG_TEST, 32'(c));
         wr(REG_CTRL, 32'h04);
         if (c < 3) begin
            for (int n = 0; n < 30 && tx_symbol !== SYM_POS; n++) @(posedge clk);
            chk(tx_symbol, SYM_POS);
            for (int i = 1; i < 4 * RUN; i++) begin
               @(posedge clk);
               if (c == 1) chk(tx_symbol, (i % 2) ? SYM_NEG : SYM_POS);
               else chk(tx_symbol, ((i / RUN) % 2) ? SYM_NEG : SYM_POS);
            end
         end else begin
            cyc(2);
            chk(force_master, 1'b1);
            for (int v = 0; v < 3; v++) begin
               tx_symbol_in <= (v == 0) ? SYM_POS : ((v == 1) ? SYM_NEG : SYM_ZERO);
               cyc(3);
               chk(tx_symbol, (v == 0) ? SYM_POS : ((v == 1) ? SYM_NEG : SYM_ZERO));
            end
         end
         wr(REG_CTRL, 32'h05);
      end
      wr(REG_TEST, 32'h0);
      tx_symbol_in <= SYM_POS;
      wr(REG_CTRL, 32'h0D);
      cyc(4);
      chk(tx_symbol, SYM_ZERO);
      chk({tx_path_enable, rx_path_enable}, 2'b11);
      rd(REG_STAT);
      chk(q[ST_SIL], 1'b1);
      wr(REG_CTRL, 32'h0C);
      cyc(4);
      chk(tx_symbol, SYM_POS);
      rd(REG_STAT);
      chk(q[ST_SIL], 1'b0);
      // Unmapped read and masked write
      rd(8'h10);
      chk(q, 32'h0);
      be = 4'hE;
      wr(REG_TEST, 32'h2);
      be = 4'hF;
      rd(REG_TEST);
      chk(q, 32'h0);
      ext_a <= 1'b0;
      ext_b <= 1'b1;
      wr(REG_CTRL, 32'h22);
      cyc(10);
      rd(REG_STAT);
      chk(q & 32'h60, 32'h40);
      // strap high on a hardware reset
      ext_a <= 1'b1;
      high_swing_strap_n <= 1'b1;
      do_reset;
      rd(REG_STAT);
      chk(q, 32'h0000_0062);
      wr(REG_CTRL, 32'h02);
      cyc(2);
      chk({high_swing_allowed, high_swing_active}, 2'b00);
      report_and_stop;
   end

endmodule
`default_nettype wire

// [hdl/pte_symgen.sv]
`timescale 1ns/1ps
`default_nettype none
module pte_symgen
   import pte_pkg::*;
#(
   parameter int unsigned RUN_LEN = DROOP_RUN
) (
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire logic      enable,
   input  wire pte_test_e mode,
   output logic [1:0]     symbol
);

   localparam int unsigned CW = (RUN_LEN > 1) ? $clog2(RUN_LEN) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          neg;
      logic [1:0]    sym;
   } pte_gen_s;

   pte_gen_s st_q;
   pte_gen_s st_d;

   always_comb begin
      st_d = st_q;
      if (!enable) begin
         st_d = '0;
      end else begin
         case (mode)
            PTE_TM_ALT: begin
               st_d.cnt = '0;
               st_d.sym = st_q.neg ? SYM_NEG : SYM_POS;
               st_d.neg = ~st_q.neg;
            end
            PTE_TM_DROOP: begin
               st_d.sym = st_q.neg ? SYM_NEG : SYM_POS;
               if (st_q.cnt == CW'(RUN_LEN - 1)) begin
                  st_d.cnt = '0;
                  st_d.neg = ~st_q.neg;
               end else begin
                  st_d.cnt = CW'(st_q.cnt + 1'b1);
               end
            end
            default: begin
               st_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign symbol = st_q.sym;

endmodule
`default_nettype wire

// [hdl/pte_top.sv]
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pte_top
   import pte_pkg::*;
#(
   parameter int unsigned PD_CYCLES    = PD_SETTLE_CYC,
   parameter int unsigned SENSE_CYCLES = SENSE_CYC,
   parameter int unsigned RUN_LEN      = DROOP_RUN
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  tx_symbol_in,
   output logic [1:0]       tx_symbol,
   output logic             tx_path_enable,
   output logic             rx_path_enable,
   output logic             force_master,
   input  wire logic        high_swing_strap_n,
   output logic             high_swing_allowed,
   output logic             high_swing_active,
   input  wire logic        led_state_a,
   input  wire logic        led_state_b,
   input  wire logic        indicator_pin_a_i,
   output logic             indicator_pin_a_o,
   output logic             indicator_pin_a_oe,
   output logic             indicator_pin_a_pull_up,
   input  wire logic        indicator_pin_b_i,
   output logic             indicator_pin_b_o,
   output logic             indicator_pin_b_oe,
   output logic             indicator_pin_b_pull_down
);

   localparam int unsigned PW = $clog2(PD_CYCLES + 1);
   localparam int unsigned SW = (SENSE_CYCLES > 1) ? $clog2(SENSE_CYCLES) : 1;

   typedef struct packed {
      logic          ack;
      logic [31:0]   rdata;
      logic          pd_req;
      logic          autoneg_en;
      logic          forced;
      logic          silence;
      logic          low_swing;
      pte_test_e     test_sel;
      pte_pol_e      pol_a;
      pte_pol_e      pol_b;
      logic [PW-1:0] pd_cnt;
      logic          pd_reached;
      logic          strap_done;
      logic          strap_hi;
      logic          sensing;
      logic [SW-1:0] sense_cnt;
      logic          low_a;
      logic          low_b;
      logic [1:0]    sym;
      logic          tx_en;
      logic          rx_en;
      logic          master;
      logic          pin_a_o;
      logic          pin_b_o;
      logic          pin_oe;
   } pte_state_s;

   pte_state_s  st_q;
   pte_state_s  st_d;
   logic        req;
   logic        wr_go;
   logic [31:0] rd;
   logic        run_ready;
   logic        mode_sil;
   logic        mode_pd;
   logic        mode_pat;
   logic        act_low_a;
   logic        act_low_b;
   logic [1:0]  gen_sym;

   pte_symgen #(
      .RUN_LEN (RUN_LEN)
   ) pte_symgen_i (
      .clk    (clk),
      .nrst   (nrst),
      .enable (mode_pat),
      .mode   (st_q.test_sel),
      .symbol (gen_sym)
   );

   assign run_ready = ~st_q.autoneg_en & st_q.forced;
   assign mode_sil  = st_q.silence & run_ready;
   assign mode_pd   = st_q.pd_req & ~mode_sil;
   assign mode_pat  = run_ready & ~st_q.pd_req & ~st_q.silence & (st_q.test_sel != PTE_TM_OFF);

   assign act_low_a = (st_q.pol_a == PTE_POL_LOW) | ((st_q.pol_a != PTE_POL_HIGH) & st_q.low_a);
   assign act_low_b = (st_q.pol_b == PTE_POL_LOW) | ((st_q.pol_b != PTE_POL_HIGH) & st_q.low_b);

   // One wait cycle per access keeps read data registered
   assign req   = avs_read | avs_write;
   assign wr_go = avs_write & st_q.ack & avs_byteenable[0];

   always_comb begin
      rd = '0;
      case (avs_address)
         REG_CTRL: begin
            rd[CTRL_PD]    = st_q.pd_req;
            rd[CTRL_AN]    = st_q.autoneg_en;
            rd[CTRL_FRC]   = st_q.forced;
            rd[CTRL_SIL]   = st_q.silence;
            rd[CTRL_LOWSW] = st_q.low_swing;
         end
         REG_TEST: begin
            rd[TEST_LSB +: 2] = st_q.test_sel;
         end
         REG_LED: begin
            rd[POL_A_LSB +: 2] = st_q.pol_a;
            rd[POL_B_LSB +: 2] = st_q.pol_b;
         end
         REG_STAT: begin
            rd[ST_PD_RDY]  = st_q.pd_reached;
            rd[ST_STRAP]   = st_q.strap_hi;
            rd[ST_HSW]     = high_swing_active;
            rd[ST_SIL]     = mode_sil;
            rd[ST_PAT]     = mode_pat;
            rd[ST_LOW_A]   = st_q.low_a;
            rd[ST_LOW_B]   = st_q.low_b;
            rd[ST_SENSING] = st_q.sensing;
         end
         default: begin
            rd = '0;
         end
      endcase
   end

   always_comb begin
      st_d     = st_q;
      st_d.ack = req & ~st_q.ack;
      if (req && !st_q.ack) begin
         st_d.rdata = rd;
      end

      // Strap is caught on the first edge after reset release
      if (!st_q.strap_done) begin
         st_d.strap_done = 1'b1;
         st_d.strap_hi   = high_swing_strap_n;
      end

      if (st_q.sensing) begin
         if (st_q.sense_cnt == SW'(SENSE_CYCLES - 1)) begin
            st_d.sensing = 1'b0;
            st_d.low_a   = indicator_pin_a_i;
            st_d.low_b   = indicator_pin_b_i;
         end else begin
            st_d.sense_cnt = SW'(st_q.sense_cnt + 1'b1);
         end
      end

      if (wr_go) begin
         case (avs_address)
            REG_CTRL: begin
               st_d.pd_req    = avs_writedata[CTRL_PD];
               st_d.autoneg_en = avs_writedata[CTRL_AN];
               st_d.forced    = avs_writedata[CTRL_FRC];
               st_d.low_swing = avs_writedata[CTRL_LOWSW];
               st_d.silence   = avs_writedata[CTRL_SIL] & (avs_writedata[CTRL_PD] | ~st_q.silence);
               if (avs_writedata[CTRL_SRST]) begin
                  st_d.sensing   = 1'b1;
                  st_d.sense_cnt = '0;
               end
            end
            REG_TEST: begin
               st_d.test_sel = pte_test_e'(avs_writedata[TEST_LSB +: 2]);
            end
            REG_LED: begin
               st_d.pol_a = pte_pol_e'(avs_writedata[POL_A_LSB +: 2]);
               st_d.pol_b = pte_pol_e'(avs_writedata[POL_B_LSB +: 2]);
            end
            default: begin
               st_d.pol_a = st_q.pol_a;
            end
         endcase
      end

      if (!st_d.pd_req) begin
         st_d.pd_cnt = '0;
      end else if (st_q.pd_cnt != PW'(PD_CYCLES)) begin
         st_d.pd_cnt = PW'(st_q.pd_cnt + 1'b1);
      end
      st_d.pd_reached = st_d.pd_req & (st_d.pd_cnt == PW'(PD_CYCLES));

      if (mode_sil) begin
         st_d.sym    = SYM_ZERO;
         st_d.tx_en  = 1'b1;
         st_d.rx_en  = 1'b1;
         st_d.master = 1'b0;
      end else if (mode_pd) begin
         st_d.sym    = SYM_ZERO;
         st_d.tx_en  = 1'b0;
         st_d.rx_en  = 1'b0;
         st_d.master = 1'b0;
      end else if (mode_pat) begin
         st_d.sym    = (st_q.test_sel == PTE_TM_IDLE) ? tx_symbol_in : gen_sym;
         st_d.tx_en  = 1'b1;
         st_d.rx_en  = 1'b1;
         st_d.master = (st_q.test_sel == PTE_TM_IDLE);
      end else begin
         st_d.sym    = tx_symbol_in;
         st_d.tx_en  = 1'b1;
         st_d.rx_en  = 1'b1;
         st_d.master = 1'b0;
      end

      st_d.pin_oe  = ~st_d.sensing;
      st_d.pin_a_o = ~st_d.sensing & (act_low_a ? ~led_state_a : led_state_a);
      st_d.pin_b_o = ~st_d.sensing & (act_low_b ? ~led_state_b : led_state_b);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q         <= '0;
         st_q.autoneg_en <= CTRL_RESET[CTRL_AN];
         st_q.sensing <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = req & ~st_q.ack;
   assign tx_symbol       = st_q.sym;
   assign tx_path_enable  = st_q.tx_en;
   assign rx_path_enable  = st_q.rx_en;
   assign force_master    = st_q.master;

   assign high_swing_allowed = st_q.strap_done & ~st_q.strap_hi;
   assign high_swing_active  = high_swing_allowed & ~st_q.low_swing;

   assign indicator_pin_a_o  = st_q.pin_a_o;
   assign indicator_pin_b_o  = st_q.pin_b_o;
   assign indicator_pin_a_oe = st_q.pin_oe;
   assign indicator_pin_b_oe = st_q.pin_oe;
   assign indicator_pin_a_pull_up   = 1'b1;
   assign indicator_pin_b_pull_down = 1'b1;

   // Helper: counts repeats of the same line symbol while the droop pattern runs, else holds zero
   localparam int PD_WAIT = PD_CYCLES + 1;
   logic [1:0] prev_sym_q;
   logic [7:0] rep_q;
   logic       alt_run;
   logic       droop_run;
   assign alt_run   = mode_pat & (st_q.test_sel == PTE_TM_ALT);
   assign droop_run = mode_pat & (st_q.test_sel == PTE_TM_DROOP);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_sym_q <= 2'h0;
         rep_q      <= 8'h00;
      end else begin
         prev_sym_q <= tx_symbol;
         rep_q      <= (tx_symbol == prev_sym_q && droop_run) ? 8'(rep_q + 1'b1) : 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   pd_reach_a: assert property ((st_q.pd_req && !st_q.pd_reached) |-> ##[1:PD_WAIT] (st_q.pd_reached || !st_q.pd_req))
      else $error("power-down reached flag late");
   pd_drop_a: assert property (!st_q.pd_req |-> !st_q.pd_reached)
      else $error("reached flag set without request");
   swing_lock_a: assert property ((st_q.strap_done && st_q.strap_hi) |-> !high_swing_active && !high_swing_allowed)
      else $error("high swing with strap high");
   swing_free_a: assert property ((st_q.strap_done && !st_q.strap_hi && !st_q.low_swing) |-> high_swing_active)
      else $error("high swing not allowed with strap low");
   silence_zero_a: assert property (mode_sil |=> tx_symbol == SYM_ZERO && tx_path_enable && rx_path_enable)
      else $error("silence mode sends nonzero or path off");
   alt_toggle_a: assert property (alt_run [*4] |-> tx_symbol != SYM_ZERO && tx_symbol != $past(tx_symbol))
      else $error("alternating pattern broken");
   droop_run_a: assert property (droop_run [*4] |-> rep_q < 8'(RUN_LEN))
      else $error("droop run too long");
   sense_quiet_a: assert property (st_q.sensing |-> !indicator_pin_a_oe && !indicator_pin_b_oe)
      else $error("pin driven while sensing");
   pol_high_a: assert property ((!st_d.sensing && st_q.pol_a == PTE_POL_HIGH) |=> indicator_pin_a_o == $past(led_state_a))
      else $error("active high drive wrong");
   bus_wait_a: assert property ((req && !avs_waitrequest) |-> $past(avs_waitrequest) && $past(req))
      else $error("access answered without wait cycle");

   pd_reach_c: cover property ($rose(st_q.pd_reached));
   alt_run_c: cover property (alt_run [*6]);
   droop_full_c: cover property (rep_q == 8'(RUN_LEN - 1));
   silence_c: cover property (mode_sil ##1 !mode_sil);

endmodule
`default_nettype wire

// [inc/pte_pkg.sv]
`default_nettype none
package pte_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned PD_SETTLE_NS  = 1000;
   localparam int unsigned PD_SETTLE_CYC = (PD_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SENSE_NS      = 320;
   localparam int unsigned SENSE_CYC     = (SENSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned DROOP_RUN     = 10;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TEST = 8'h04;
   localparam logic [7:0] REG_LED  = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;

   // Control register fields
   localparam int unsigned CTRL_PD    = 0;
   localparam int unsigned CTRL_AN    = 1;
   localparam int unsigned CTRL_FRC   = 2;
   localparam int unsigned CTRL_SIL   = 3;
   localparam int unsigned CTRL_LOWSW = 4;
   localparam int unsigned CTRL_SRST  = 5;
   localparam logic [5:0]  CTRL_RESET = 6'h02;

   // Test and LED register fields
   localparam int unsigned TEST_LSB  = 0;
   localparam int unsigned POL_A_LSB = 0;
   localparam int unsigned POL_B_LSB = 2;

   // Status register fields
   localparam int unsigned ST_PD_RDY  = 0;
   localparam int unsigned ST_STRAP   = 1;
   localparam int unsigned ST_HSW     = 2;
   localparam int unsigned ST_SIL     = 3;
   localparam int unsigned ST_PAT     = 4;
   localparam int unsigned ST_LOW_A   = 5;
   localparam int unsigned ST_LOW_B   = 6;
   localparam int unsigned ST_SENSING = 7;

   typedef enum logic [1:0] {
      PTE_TM_OFF   = 2'b00,
      PTE_TM_ALT   = 2'b01,
      PTE_TM_DROOP = 2'b10,
      PTE_TM_IDLE  = 2'b11
   } pte_test_e;

   typedef enum logic [1:0] {
      PTE_POL_AUTO = 2'b00,
      PTE_POL_LOW  = 2'b01,
      PTE_POL_HIGH = 2'b10,
      PTE_POL_RSVD = 2'b11
   } pte_pol_e;

   // Line symbol codes
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_POS  = 2'h1;
   localparam logic [1:0] SYM_NEG  = 2'h3;

endpackage
`default_nettype wire
